// >>> core/lu_pkg.sv
/*
  Shared constants of the line-unit interrupt qualification block: register
  offsets, field positions, reset values and timing figures.
  Assumes a single 50 MHz core clock feeding every module of the block.
*/
package lu_pkg;
  // Host register offsets.
  localparam logic [7:0] OFS_MASK_FIRST = 8'h11;
  localparam logic [7:0] OFS_MASK_SECOND = 8'h12;
  localparam logic [7:0] OFS_EDGE_SEL = 8'h13;
  localparam logic [7:0] OFS_STATUS_FIRST = 8'h14;
  localparam logic [7:0] OFS_STATUS_SECOND = 8'h15;
  localparam logic [7:0] OFS_LATCH_FIRST = 8'h16;
  localparam logic [7:0] OFS_LATCH_SECOND = 8'h17;
  // Line status and edge-select bit positions.
  localparam int BIT_ACTIVATE = 6;
  localparam int BIT_DEACTIVATE = 5;
  localparam int BIT_PATTERN_SYNC = 4;
  localparam int BIT_TX_CLOCK_LOSS = 3;
  localparam int BIT_DRIVER_FAULT = 2;
  localparam int BIT_ALARM = 1;
  localparam int BIT_SIGNAL_LOSS = 0;
  // Second mask register bit positions, then the remote loop bit of the second status register.
  localparam int BIT_DAC_OVERFLOW = 7;
  localparam int BIT_JITTER_OVER = 6;
  localparam int BIT_JITTER_UNDER = 5;
  localparam int BIT_PATTERN_ERROR = 4;
  localparam int BIT_EXCESS_ZEROS = 3;
  localparam int BIT_CODE_VIOLATION = 2;
  localparam int BIT_SECOND_TICK = 1;
  localparam int BIT_COUNTER_OVERFLOW = 0;
  localparam int BIT_REMOTE_LOOP = 5;
  // Reset values.
  localparam logic [6:0] RST_MASK_FIRST = 7'h7f;
  localparam logic [7:0] RST_MASK_SECOND = 8'hff;
  localparam logic [6:0] RST_EDGE_SEL = 7'h00;
  // Timing.
  localparam int CLK_KHZ = 50000;
  localparam int QUAL_SHORT_MS = 40;
  localparam int QUAL_LONG_MS = 5100;
  localparam int QUAL_SHORT_CYCLES = CLK_KHZ * QUAL_SHORT_MS;
  localparam int QUAL_LONG_CYCLES = CLK_KHZ * QUAL_LONG_MS;
  localparam int TX_CLOCK_LOSS_CYCLES = 70;
  localparam int BER_WINDOW_BITS = 100;
  localparam int BER_ERROR_LIMIT = 2;
endpackage : lu_pkg

// >>> core/lu_code_qual.sv
/*
  Inband loop code qualifier: raises its flag after the code has been seen
  without a break for longer than the qualification time, then holds it
  while the error rate stays below two errors per hundred bits.
  Assumes code_seen_in, bit_tick_in and bit_error_in come from the pattern
  matcher on the same clock.
*/
module lu_code_qual
  import lu_pkg::*;
#(
  parameter int QUAL_W = 28
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Matcher side.
  input wire logic code_seen_in,
  input wire logic bit_tick_in,
  input wire logic bit_error_in,
  input wire logic [QUAL_W-1:0] qual_cycles_in,
  // Result.
  output logic detected_out
);
  typedef enum logic [1:0] {LU_IDLE, LU_QUALIFY, LU_HOLD} lu_qual_state_t;
  lu_qual_state_t state_reg, state_next;
  logic [QUAL_W-1:0] cnt_reg, cnt_next;
  logic [6:0] bits_reg, bits_next;
  logic [1:0] errs_reg, errs_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bits_next = bits_reg;
    errs_next = errs_reg;
    case (state_reg)
      LU_IDLE: begin
        cnt_next = '0;
        if (code_seen_in) begin
          state_next = LU_QUALIFY;
        end
      end
      LU_QUALIFY: begin
        cnt_next = cnt_reg + 1'b1;
        if (!code_seen_in) begin
          state_next = LU_IDLE;
        end else if (cnt_reg >= qual_cycles_in) begin
          state_next = LU_HOLD;
          bits_next = '0;
          errs_next = '0;
        end
      end
      LU_HOLD: begin
        if (bit_tick_in) begin
          if (bit_error_in && errs_reg == 2'(BER_ERROR_LIMIT - 1)) begin
            state_next = LU_IDLE;
          end else if (bits_reg == 7'(BER_WINDOW_BITS - 1)) begin
            bits_next = '0;
            errs_next = '0;
          end else begin
            bits_next = bits_reg + 1'b1;
            errs_next = errs_reg + 2'(bit_error_in);
          end
        end
      end
      default: state_next = LU_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= LU_IDLE;
      cnt_reg <= '0;
      bits_reg <= '0;
      errs_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bits_reg <= bits_next;
      errs_reg <= errs_next;
    end
  end

  assign detected_out = (state_reg == LU_HOLD);
endmodule : lu_code_qual

// >>> core/lu_clk_loss.sv
/*
  Transmit clock loss monitor: flags the pin as lost once it has not
  changed for more than the loss limit of core clock cycles.
  Assumes the transmit clock pin is asynchronous to clk_in.
*/
module lu_clk_loss
  import lu_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Monitored pin.
  input wire logic transmit_clock_in,
  // Result.
  output logic tx_clock_lost_out
);
  logic [2:0] sync_reg, sync_next;
  logic level_reg, level_next;
  logic [6:0] cnt_reg, cnt_next;
  logic lost_reg, lost_next;

  always_comb begin
    sync_next = {sync_reg[1:0], transmit_clock_in};
    level_next = level_reg;
    cnt_next = cnt_reg;
    // A change counts only once the second and third stages agree.
    if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg) begin
      level_next = sync_reg[2];
      cnt_next = '0;
    end else if (cnt_reg <= 7'(TX_CLOCK_LOSS_CYCLES)) begin
      cnt_next = cnt_reg + 1'b1;
    end
    lost_next = (cnt_next > 7'(TX_CLOCK_LOSS_CYCLES));
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync_reg <= '0;
      level_reg <= 1'b0;
      cnt_reg <= '0;
      lost_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
      lost_reg <= lost_next;
    end
  end

  assign tx_clock_lost_out = lost_reg;
endmodule : lu_clk_loss

// >>> core/lu_irq_qual.sv
/*
  Per-channel interrupt qualification of a line interface unit: mask
  registers, edge selection, realtime line status, event latches that clear
  on read, remote loopback control and the interrupt output.
  Assumes a host register port on clk_in with one-cycle read and write
  strobes, and line detectors on the same clock except the transmit clock.
*/
module lu_irq_qual
  import lu_pkg::*;
#(
  parameter int QUAL_W = 28,
  parameter int QUAL_SHORT = QUAL_SHORT_CYCLES,
  parameter int QUAL_LONG = QUAL_LONG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Host register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Inband loop code matchers.
  input wire logic activate_seen_in,
  input wire logic deactivate_seen_in,
  input wire logic bit_tick_in,
  input wire logic bit_error_in,
  input wire logic auto_remote_loop_enable_in,
  // Line status sources.
  input wire logic pattern_sync_in,
  input wire logic driver_fault_in,
  input wire logic alarm_indication_in,
  input wire logic signal_loss_in,
  input wire logic transmit_clock_in,
  // Error event pulses, in second mask bit order.
  input wire logic [7:0] error_events_in,
  // Results.
  output logic remote_loop_out,
  output logic irq_out
);
  logic [6:0] mask_first_reg, mask_first_next;
  logic [7:0] mask_second_reg, mask_second_next;
  logic [6:0] edge_sel_reg, edge_sel_next;
  logic [6:0] status_prev_reg, status_prev_next;
  logic [6:0] latch_first_reg, latch_first_next;
  logic [7:0] latch_second_reg, latch_second_next;
  logic remote_loop_reg, remote_loop_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic [6:0] status_now;
  logic [6:0] line_events;
  logic activate_detected;
  logic deactivate_detected;
  logic tx_clock_lost;
  logic [QUAL_W-1:0] qual_cycles;

  // Offset decode shared by the write and clear paths; the read path decodes with its own case.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  assign qual_cycles = auto_remote_loop_enable_in ? QUAL_W'(QUAL_LONG)
                                                  : QUAL_W'(QUAL_SHORT);

  lu_code_qual #(
    .QUAL_W(QUAL_W)
  ) u_activate_qual (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .code_seen_in(activate_seen_in),
    .bit_tick_in(bit_tick_in),
    .bit_error_in(bit_error_in),
    .qual_cycles_in(qual_cycles),
    .detected_out(activate_detected)
  );

  lu_code_qual #(
    .QUAL_W(QUAL_W)
  ) u_deactivate_qual (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .code_seen_in(deactivate_seen_in),
    .bit_tick_in(bit_tick_in),
    .bit_error_in(bit_error_in),
    .qual_cycles_in(qual_cycles),
    .detected_out(deactivate_detected)
  );

  lu_clk_loss u_clk_loss (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .transmit_clock_in(transmit_clock_in),
    .tx_clock_lost_out(tx_clock_lost)
  );

  always_comb begin
    status_now = '0;
    status_now[BIT_ACTIVATE] = activate_detected;
    status_now[BIT_DEACTIVATE] = deactivate_detected;
    status_now[BIT_PATTERN_SYNC] = pattern_sync_in;
    status_now[BIT_TX_CLOCK_LOSS] = tx_clock_lost;
    status_now[BIT_DRIVER_FAULT] = driver_fault_in;
    status_now[BIT_ALARM] = alarm_indication_in;
    status_now[BIT_SIGNAL_LOSS] = signal_loss_in;
  end

  for (genvar i = 0; i < 7; i++) begin : g_line_event
    logic rose;
    logic fell;
    assign rose = status_now[i] && !status_prev_reg[i];
    assign fell = !status_now[i] && status_prev_reg[i];
    assign line_events[i] = rose || (edge_sel_reg[i] && fell);
  end

  // Line status mask.
  always_comb begin
    mask_first_next = mask_first_reg;
    if (reg_wr_in && hit(reg_addr_in, OFS_MASK_FIRST)) begin
      mask_first_next = reg_wdata_in[6:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mask_first_reg <= RST_MASK_FIRST;
    end else begin
      mask_first_reg <= mask_first_next;
    end
  end

  // Error event mask.
  always_comb begin
    mask_second_next = mask_second_reg;
    if (reg_wr_in && hit(reg_addr_in, OFS_MASK_SECOND)) begin
      mask_second_next = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mask_second_reg <= RST_MASK_SECOND;
    end else begin
      mask_second_reg <= mask_second_next;
    end
  end

  // Edge select.
  always_comb begin
    edge_sel_next = edge_sel_reg;
    if (reg_wr_in && hit(reg_addr_in, OFS_EDGE_SEL)) begin
      edge_sel_next = reg_wdata_in[6:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      edge_sel_reg <= RST_EDGE_SEL;
    end else begin
      edge_sel_reg <= edge_sel_next;
    end
  end

  // Status history for edge detection.
  always_comb begin
    status_prev_next = status_now;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      status_prev_reg <= '0;
    end else begin
      status_prev_reg <= status_prev_next;
    end
  end

  // Line status event latch; a new event beats the read clear so none is lost.
  always_comb begin
    latch_first_next = latch_first_reg;
    if (reg_rd_in && hit(reg_addr_in, OFS_LATCH_FIRST)) begin
      latch_first_next = '0;
    end
    latch_first_next = latch_first_next | (line_events & ~mask_first_reg);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      latch_first_reg <= '0;
    end else begin
      latch_first_reg <= latch_first_next;
    end
  end

  // Error event latch, with the same priority as the line status latch.
  always_comb begin
    latch_second_next = latch_second_reg;
    if (reg_rd_in && hit(reg_addr_in, OFS_LATCH_SECOND)) begin
      latch_second_next = '0;
    end
    latch_second_next = latch_second_next | (error_events_in & ~mask_second_reg);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      latch_second_reg <= '0;
    end else begin
      latch_second_reg <= latch_second_next;
    end
  end

  // Remote loopback follows the qualified loop codes, whatever the masks say.
  always_comb begin
    remote_loop_next = remote_loop_reg;
    if (line_events[BIT_ACTIVATE] && activate_detected) begin
      remote_loop_next = 1'b1;
    end
    // Open on deactivate, which wins a same-cycle tie.
    if (line_events[BIT_DEACTIVATE] && deactivate_detected) begin
      remote_loop_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      remote_loop_reg <= 1'b0;
    end else begin
      remote_loop_reg <= remote_loop_next;
    end
  end

  // Interrupt is taken from the next latch values so it moves with them.
  always_comb begin
    irq_next = |(latch_first_next & ~mask_first_reg) |
               |(latch_second_next & ~mask_second_reg);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Read data is registered so a read answers one cycle after its strobe.
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_MASK_FIRST: rdata_next = {1'b0, mask_first_reg};
        OFS_MASK_SECOND: rdata_next = mask_second_reg;
        OFS_EDGE_SEL: rdata_next = {1'b0, edge_sel_reg};
        OFS_STATUS_FIRST: rdata_next = {1'b0, status_now};
        OFS_STATUS_SECOND: rdata_next = 8'(remote_loop_reg) << BIT_REMOTE_LOOP;
        OFS_LATCH_FIRST: rdata_next = {1'b0, latch_first_reg};
        OFS_LATCH_SECOND: rdata_next = latch_second_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign remote_loop_out = remote_loop_reg;
  assign irq_out = irq_reg;
endmodule : lu_irq_qual

// >>> verif/lu_irq_qual_properties.sv
/*
  Checker for the interrupt qualification block, watching its ports only.
  Assumes one clock domain and shadows the mask writes it observes.
*/
module lu_irq_qual_properties
  import lu_pkg::*;
#(
  parameter int QUAL_SHORT = QUAL_SHORT_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic activate_seen_in,
  input wire logic deactivate_seen_in,
  input wire logic transmit_clock_in,
  input wire logic [7:0] error_events_in,
  input wire logic remote_loop_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  logic [7:0] mask2_reg, mask2_next;
  logic [6:0] mask1_reg, mask1_next;
  logic [15:0] act_reg, act_next, deact_reg, deact_next, tstab_reg, tstab_next;
  logic pin_reg, pin_next;
  // Counters run in the core clock, so pin stability is only known to one cycle.
  always_comb begin
    mask2_next = mask2_reg;
    mask1_next = mask1_reg;
    if (reg_wr_in && reg_addr_in == OFS_MASK_SECOND) mask2_next = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == OFS_MASK_FIRST) mask1_next = reg_wdata_in[6:0];
    act_next = activate_seen_in ? act_reg + 16'h1 : 16'h0;
    deact_next = deactivate_seen_in ? deact_reg + 16'h1 : 16'h0;
    pin_next = transmit_clock_in;
    tstab_next = (transmit_clock_in != pin_reg) ? 16'h0 : tstab_reg + 16'h1;
    if (srst_in) begin
      mask2_next = RST_MASK_SECOND;
      mask1_next = RST_MASK_FIRST;
      act_next = 16'h0;
      deact_next = 16'h0;
      tstab_next = 16'h0;
    end
  end
  always_ff @(posedge clk_in) begin
    mask2_reg <= mask2_next;
    mask1_reg <= mask1_next;
    act_reg <= act_next;
    deact_reg <= deact_next;
    pin_reg <= pin_next;
    tstab_reg <= tstab_next;
  end
  reset_outputs_a: assert property (disable iff (1'b0) srst_in |=>
    (!irq_out && !remote_loop_out && reg_rdata_out == 8'h00)) else $error("reset outputs");
  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd_in && !(reg_addr_in inside {[8'h11:8'h17]})
    |=> reg_rdata_out == 8'h00) else $error("unmapped read");
  edge_reserved_a: assert property (reg_rd_in && reg_addr_in == OFS_EDGE_SEL
    |=> !reg_rdata_out[7]) else $error("edge select bit 7");
  status_reserved_a: assert property (reg_rd_in && reg_addr_in == OFS_STATUS_FIRST
    |=> !reg_rdata_out[7]) else $error("status bit 7");
  loop_status_a: assert property (reg_rd_in && reg_addr_in == OFS_STATUS_SECOND |=>
    reg_rdata_out == {2'b00, $past(remote_loop_out), 5'h00}) else $error("loop status");
  event_irq_a: assert property ((error_events_in & ~mask2_reg) != 8'h00 |=> irq_out)
    else $error("unmasked event without interrupt");
  masked_quiet_a: assert property (mask2_reg == 8'hff && mask1_reg == 7'h7f && !reg_wr_in
    |=> !irq_out) else $error("interrupt while all masked");
  loop_close_a: assert property ($rose(remote_loop_out) |-> act_reg >= QUAL_SHORT)
    else $error("loop closed early");
  loop_open_a: assert property ($fell(remote_loop_out) |->
    deact_reg >= QUAL_SHORT || $past(srst_in)) else $error("loop opened early");
  clock_ok_a: assert property (reg_rd_in && reg_addr_in == OFS_STATUS_FIRST &&
    tstab_reg >= 8 && tstab_reg <= 60 |=> !reg_rdata_out[3]) else $error("clock loss early");
  clock_lost_a: assert property (reg_rd_in && reg_addr_in == OFS_STATUS_FIRST &&
    tstab_reg >= 90 |=> reg_rdata_out[3]) else $error("clock loss missed");
endmodule : lu_irq_qual_properties

bind lu_irq_qual lu_irq_qual_properties #(.QUAL_SHORT(QUAL_SHORT)) i_props (
  .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .activate_seen_in(activate_seen_in), .deactivate_seen_in(deactivate_seen_in),
  .transmit_clock_in(transmit_clock_in), .error_events_in(error_events_in),
  .remote_loop_out(remote_loop_out), .irq_out(irq_out));

// >>> verif/lu_irq_qual_bench.sv
/*
  Self-checking bench for the interrupt qualification block.
  Assumes shortened qualification counts of 20 and 50 cycles.
*/
module lu_irq_qual_bench
  import lu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] mask; logic [7:0] ev; logic [7:0] lat; logic irq;} lu_row_t;
  logic clk_in = 0, srst_in = 1, wr = 0, rd = 0, act = 0, deact = 0, tick = 0, berr = 0;
  logic auto = 0, txc_pin = 0, run = 1, remote_loop, irq;
  logic [1:0] txc_div = 0;
  logic [7:0] addr = 0, wdata = 0, ev = 0, rdata, b;
  logic [3:0] ls = 0;
  int n_fail = 0, compares = 0, pos;
  lu_row_t rows [10];
  lu_irq_qual #(.QUAL_W(28), .QUAL_SHORT(20), .QUAL_LONG(50)) i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .activate_seen_in(act),
    .deactivate_seen_in(deact), .bit_tick_in(tick), .bit_error_in(berr),
    .auto_remote_loop_enable_in(auto), .pattern_sync_in(ls[3]), .driver_fault_in(ls[2]),
    .alarm_indication_in(ls[1]), .signal_loss_in(ls[0]), .transmit_clock_in(txc_pin),
    .error_events_in(ev), .remote_loop_out(remote_loop), .irq_out(irq));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // The pin holds four cycles, since the synchroniser accepts only a level seen twice.
  always @(posedge clk_in) begin
    txc_div <= txc_div + 2'h1;
    if (run && txc_div == 2'h3) txc_pin <= ~txc_pin;
  end
  task wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wrr
  task rdr(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk($sformatf("register %h", a), e, rdata);
  endtask : rdr
  task end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    wt(20000);
    n_fail++;
    end_sim();
  end
  initial begin
    rows = '{'{8'h7f, 8'h80, 8'h80, 1'b1}, '{8'hbf, 8'h40, 8'h40, 1'b1},
      '{8'hdf, 8'h20, 8'h20, 1'b1}, '{8'hef, 8'h10, 8'h10, 1'b1}, '{8'hf7, 8'h08, 8'h08, 1'b1},
      '{8'hfb, 8'h04, 8'h04, 1'b1}, '{8'hfd, 8'h02, 8'h02, 1'b1}, '{8'hfe, 8'h01, 8'h01, 1'b1},
      '{8'hff, 8'hff, 8'h00, 1'b0}, '{8'hfe, 8'hfe, 8'h00, 1'b0}};
    wt(2);
    srst_in <= 1'b0;
    rdr(OFS_MASK_FIRST, 8'h7f);
    rdr(OFS_MASK_SECOND, 8'hff);
    rdr(OFS_EDGE_SEL, 8'h00);
    rdr(8'h20, 8'h00);
    wrr(OFS_EDGE_SEL, 8'hff);
    rdr(OFS_EDGE_SEL, 8'h7f);
    wrr(OFS_STATUS_FIRST, 8'hff);
    rdr(OFS_STATUS_FIRST, 8'h00);
    wrr(OFS_EDGE_SEL, 8'h00);
    foreach (rows[i]) begin
      wrr(OFS_MASK_SECOND, rows[i].mask);
      @(posedge clk_in);
      ev <= rows[i].ev;
      @(posedge clk_in);
      ev <= 8'h00;
      #1;
      chk("irq", {7'h0, rows[i].irq}, {7'h0, irq});
      rdr(OFS_LATCH_SECOND, rows[i].lat);
      rdr(OFS_LATCH_SECOND, 8'h00);
      chk("irq", 8'h00, {7'h0, irq});
    end
    wrr(OFS_MASK_SECOND, 8'hff);
    for (int k = 0; k < 4; k++) begin
      pos = (k == 3) ? 4 : k;
      b = 8'h01 << pos;
      wrr(OFS_MASK_FIRST, ~b & 8'h7f);
      wrr(OFS_EDGE_SEL, 8'h00);
      ls[k] <= 1'b1;
      wt(2);
      rdr(OFS_STATUS_FIRST, b);
      rdr(OFS_LATCH_FIRST, b);
      ls[k] <= 1'b0;
      wt(2);
      rdr(OFS_LATCH_FIRST, 8'h00);
      wrr(OFS_EDGE_SEL, b);
      ls[k] <= 1'b1;
      wt(2);
      rdr(OFS_LATCH_FIRST, b);
      ls[k] <= 1'b0;
      wt(2);
      rdr(OFS_LATCH_FIRST, b);
    end
    wrr(OFS_EDGE_SEL, 8'h00);
    run <= 1'b0;
    wt(45);
    rdr(OFS_STATUS_FIRST, 8'h00);
    wt(50);
    rdr(OFS_STATUS_FIRST, 8'h08);
    run <= 1'b1;
    wt(10);
    rdr(OFS_STATUS_FIRST, 8'h00);
    wrr(OFS_MASK_FIRST, 8'h3f);
    act <= 1'b1;
    wt(10);
    rdr(OFS_STATUS_FIRST, 8'h00);
    wt(20);
    rdr(OFS_STATUS_FIRST, 8'h40);
    chk("loop", 8'h01, {7'h0, remote_loop});
    rdr(OFS_STATUS_SECOND, 8'h20);
    chk("irq", 8'h01, {7'h0, irq});
    rdr(OFS_LATCH_FIRST, 8'h40);
    tick <= 1'b1;
    for (int j = 0; j < 20; j++) begin
      @(posedge clk_in);
      berr <= (j == 5);
    end
    rdr(OFS_STATUS_FIRST, 8'h40);
    act <= 1'b0;
    berr <= 1'b1;
    wt(2);
    berr <= 1'b0;
    tick <= 1'b0;
    wt(3);
    rdr(OFS_STATUS_FIRST, 8'h00);
    rdr(OFS_LATCH_FIRST, 8'h00);
    deact <= 1'b1;
    wt(30);
    chk("loop", 8'h00, {7'h0, remote_loop});
    rdr(OFS_STATUS_FIRST, 8'h20);
    deact <= 1'b0;
    srst_in <= 1'b1;
    wt(2);
    srst_in <= 1'b0;
    auto <= 1'b1;
    act <= 1'b1;
    wt(35);
    rdr(OFS_STATUS_FIRST, 8'h00);
    wt(25);
    rdr(OFS_STATUS_FIRST, 8'h40);
    end_sim();
  end
endmodule : lu_irq_qual_bench
